// [verilog/mpvr_core.sv]
`timescale 1ns/1ps
module mpvr_core #(
  parameter int FAULT_CYCLES = mpvr_pkg::ILIM_FAULT_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic bridgeControlA,
  input wire logic bridgeControlB,
  input wire logic [5:0] outputVoltageSetpoint,
  input wire logic faultResetRequest,
  input wire logic senseResistorPin,
  input wire logic [7:0] windingAverage,
  input wire logic [7:0] supplyLevel,
  output mpvr_pkg::mpvr_drive_s drive,
  output logic faultOutputLow,
  output logic faultFlag,
  output logic currentLimitFlag,
  output logic currentLimiting,
  output logic regulating,
  output logic [8:0] dutyLevel
);
  localparam int LT_W = $clog2(FAULT_CYCLES + 1);
  localparam logic [LT_W-1:0] LT_LAST = LT_W'(FAULT_CYCLES - 1);

  // ==========================================================
  // helpers
  function automatic mpvr_pkg::mpvr_mode_e modeOf(input logic a, input logic b);
    case ({a, b})
      2'h1: modeOf = mpvr_pkg::MPVR_REVERSE;
      2'h2: modeOf = mpvr_pkg::MPVR_FORWARD;
      2'h3: modeOf = mpvr_pkg::MPVR_BRAKE;
      default: modeOf = mpvr_pkg::MPVR_COAST;
    endcase
  endfunction

  // level in units of vref/64, i.e. output voltage divided by four
  function automatic logic [6:0] dacLevel(input logic [5:0] code);
    dacLevel = {1'b0, code} + 7'h01;
  endfunction

  function automatic logic isDriving(input mpvr_pkg::mpvr_mode_e m);
    isDriving = (m == mpvr_pkg::MPVR_FORWARD) || (m == mpvr_pkg::MPVR_REVERSE);
  endfunction

  // ==========================================================
  // sense comparator synchroniser and deglitch
  logic senseSync1_reg, senseSync2_reg;
  logic senseSync1_next, senseSync2_next;
  logic [6:0] overCnt_reg, overCnt_next;
  logic limiting_reg, limiting_next;

  always_comb begin
    senseSync1_next = senseResistorPin;
    senseSync2_next = senseSync1_reg;
    overCnt_next = 7'h00;
    if (senseSync2_reg) begin
      overCnt_next = (overCnt_reg == mpvr_pkg::DEGLITCH_LAST) ? overCnt_reg
                                                               : overCnt_reg + 7'h01;
    end
    limiting_next = senseSync2_reg && (overCnt_reg == mpvr_pkg::DEGLITCH_LAST);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      senseSync1_reg <= 1'b0;
      senseSync2_reg <= 1'b0;
      overCnt_reg <= 7'h00;
      limiting_reg <= 1'b0;
    end else if (clkEn) begin
      senseSync1_reg <= senseSync1_next;
      senseSync2_reg <= senseSync2_next;
      overCnt_reg <= overCnt_next;
      limiting_reg <= limiting_next;
    end
  end

  // ==========================================================
  // pwm period, setpoint latch and duty regulation
  mpvr_pkg::mpvr_mode_e mode, modePrev_reg, modePrev_next;
  logic [8:0] periodCnt_reg, periodCnt_next;
  logic [8:0] duty_reg, duty_next;
  logic [5:0] setCode_reg, setCode_next;
  logic setValid_reg, setValid_next;
  logic regulating_reg, regulating_next;
  logic limitCut_reg, limitCut_next;
  logic periodEnd, entering, fullCmd, fbBelow, fbAbove;
  logic [6:0] target;
  logic [5:0] fbScaled;

  always_comb begin
    mode = modeOf(bridgeControlA, bridgeControlB);
    periodEnd = (periodCnt_reg == mpvr_pkg::PERIOD_LAST);
    entering = isDriving(mode) && !isDriving(modePrev_reg);
    target = setValid_reg ? dacLevel(setCode_reg) : 7'h00;
    fbScaled = windingAverage[7:2];
    fbBelow = {1'b0, fbScaled} < target;
    fbAbove = {1'b0, fbScaled} > target;
    fullCmd = setValid_reg && ({dacLevel(setCode_reg), 2'h0} > {1'b0, supplyLevel});
    modePrev_next = mode;
    periodCnt_next = periodEnd ? 9'h000 : periodCnt_reg + 9'h001;
    setCode_next = setCode_reg;
    setValid_next = setValid_reg;
    duty_next = duty_reg;
    regulating_next = regulating_reg;
    limitCut_next = limitCut_reg || limiting_reg;
    if (periodEnd) begin
      // setpoint only moves on a period boundary so duty never jumps mid-pulse
      setCode_next = outputVoltageSetpoint;
      setValid_next = (outputVoltageSetpoint > mpvr_pkg::SET_RESERVED_MAX);
      limitCut_next = limiting_reg;
    end
    if (!isDriving(mode)) begin
      duty_next = mpvr_pkg::DUTY_RESET;
      regulating_next = 1'b0;
    end else if (entering) begin
      duty_next = mpvr_pkg::DUTY_RESET;
      periodCnt_next = 9'h000;
      regulating_next = 1'b0;
    end else if (periodEnd) begin
      regulating_next = !fullCmd;
      if (limiting_reg || limitCut_reg) begin
        if (duty_reg != 9'h000) begin
          duty_next = duty_reg - 9'h001;
        end
      end else if (fullCmd || fbBelow) begin
        // one step per period doubles as the start-up ramp
        if (duty_reg != mpvr_pkg::DUTY_FULL) begin
          duty_next = duty_reg + 9'h001;
        end
      end else if ((fbAbove || !setValid_reg) && duty_reg != 9'h000) begin
        // zero command: feedback never reads below zero, so walk down regardless
        duty_next = duty_reg - 9'h001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      modePrev_reg <= mpvr_pkg::MPVR_COAST;
      periodCnt_reg <= 9'h000;
      duty_reg <= mpvr_pkg::DUTY_RESET;
      setCode_reg <= 6'h00;
      setValid_reg <= 1'b0;
      regulating_reg <= 1'b0;
      limitCut_reg <= 1'b0;
    end else if (clkEn) begin
      modePrev_reg <= modePrev_next;
      periodCnt_reg <= periodCnt_next;
      duty_reg <= duty_next;
      setCode_reg <= setCode_next;
      setValid_reg <= setValid_next;
      regulating_reg <= regulating_next;
      limitCut_reg <= limitCut_next;
    end
  end

  // ==========================================================
  // bridge drive
  mpvr_pkg::mpvr_drive_s drive_reg, drive_next;
  logic pwmOn;

  always_comb begin
    // fault state is not an input here: a fault keeps the bridge running
    pwmOn = (periodCnt_reg < duty_reg) && !limitCut_reg && !limiting_reg;
    drive_next = mpvr_pkg::DRIVE_OFF;
    case (mode)
      mpvr_pkg::MPVR_FORWARD: begin
        drive_next.highA = 1'b1;
        drive_next.lowB = pwmOn;
        drive_next.highB = !pwmOn;
      end
      mpvr_pkg::MPVR_REVERSE: begin
        drive_next.highB = 1'b1;
        drive_next.lowA = pwmOn;
        drive_next.highA = !pwmOn;
      end
      mpvr_pkg::MPVR_BRAKE: begin
        drive_next.highA = 1'b1;
        drive_next.highB = 1'b1;
      end
      default: drive_next = mpvr_pkg::DRIVE_OFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      drive_reg <= mpvr_pkg::DRIVE_OFF;
    end else if (clkEn) begin
      drive_reg <= drive_next;
    end
  end

  // ==========================================================
  // current-limit persistence and fault latch
  logic [LT_W-1:0] limTimer_reg, limTimer_next;
  logic fault_reg, fault_next;
  logic faultPin_reg, faultPin_next;
  logic faultSet, faultClear;

  always_comb begin
    limTimer_next = {LT_W{1'b0}};
    if (limiting_reg) begin
      limTimer_next = (limTimer_reg == LT_LAST) ? limTimer_reg : limTimer_reg + LT_W'(1);
    end
    faultSet = limiting_reg && (limTimer_reg == LT_LAST);
    faultClear = (mode == mpvr_pkg::MPVR_COAST) || faultResetRequest;
    // set wins so an overload in the clearing cycle is not lost
    fault_next = faultSet || (fault_reg && !faultClear);
    faultPin_next = !fault_next;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      limTimer_reg <= {LT_W{1'b0}};
      fault_reg <= 1'b0;
      faultPin_reg <= 1'b1;
    end else if (clkEn) begin
      limTimer_reg <= limTimer_next;
      fault_reg <= fault_next;
      faultPin_reg <= faultPin_next;
    end
  end

  assign drive = drive_reg;
  assign faultOutputLow = faultPin_reg;
  assign faultFlag = fault_reg;
  assign currentLimitFlag = fault_reg;
  assign currentLimiting = limiting_reg;
  assign regulating = regulating_reg;
  assign dutyLevel = duty_reg;

  // ==========================================================
  // assertions
  property p_fbRaise;
    @(posedge clk_sys) disable iff (reset || !clkEn)
      periodEnd && isDriving(mode) && !entering && !limiting_reg && !limitCut_reg && !fullCmd
      && fbBelow && duty_reg != mpvr_pkg::DUTY_FULL |=> duty_reg == $past(duty_reg) + 9'h001;
  endproperty
  a_fbRaise: assert property (p_fbRaise) else $error("duty not raised below setpoint");

  property p_fbLower;
    @(posedge clk_sys) disable iff (reset || !clkEn)
      periodEnd && isDriving(mode) && !entering && !fullCmd && windingAverage[7:2] > 6'(target)
      && target[6] == 1'b0 && duty_reg != 9'h000 |=> duty_reg == $past(duty_reg) - 9'h001;
  endproperty
  a_fbLower: assert property (p_fbLower) else $error("duty not lowered above setpoint");

  property p_forwardOn;
    @(posedge clk_sys) disable iff (reset || !clkEn)
      mode == mpvr_pkg::MPVR_FORWARD && pwmOn |=> drive.highA && drive.lowB && !drive.highB
      && !drive.lowA;
  endproperty
  a_forwardOn: assert property (p_forwardOn) else $error("forward on phase wrong");

  property p_offPhase;
    @(posedge clk_sys) disable iff (reset || !clkEn)
      isDriving(mode) && !pwmOn |=> drive.highA && drive.highB && !drive.lowA && !drive.lowB;
  endproperty
  a_offPhase: assert property (p_offPhase) else $error("off phase not recirculating");

  property p_fullDuty;
    @(posedge clk_sys) disable iff (reset || !clkEn)
      periodEnd && isDriving(mode) && !entering && fullCmd && !limiting_reg && !limitCut_reg
      |=> !regulating && duty_reg >= $past(duty_reg);
  endproperty
  a_fullDuty: assert property (p_fullDuty) else $error("full duty not held");

  property p_reserved;
    @(posedge clk_sys) disable iff (reset || !clkEn)
      periodEnd && outputVoltageSetpoint <= mpvr_pkg::SET_RESERVED_MAX |=> target == 7'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code not zero");

  property p_deglitch;
    @(posedge clk_sys) disable iff (reset || !clkEn)
      senseSync2_reg && overCnt_reg == mpvr_pkg::DEGLITCH_LAST |=> limiting_reg ##1 !pwmOn;
  endproperty
  a_deglitch: assert property (p_deglitch) else $error("limit not engaged");

  property p_faultSet;
    @(posedge clk_sys) disable iff (reset || !clkEn)
      faultSet |=> faultFlag && currentLimitFlag && !faultOutputLow;
  endproperty
  a_faultSet: assert property (p_faultSet) else $error("fault not registered");

  property p_faultClear;
    @(posedge clk_sys) disable iff (reset || !clkEn)
      faultResetRequest && !faultSet |=> !faultFlag && faultOutputLow;
  endproperty
  a_faultClear: assert property (p_faultClear) else $error("fault not cleared");

  property p_coast;
    @(posedge clk_sys) disable iff (reset || !clkEn)
      mode == mpvr_pkg::MPVR_COAST |=> drive == mpvr_pkg::DRIVE_OFF && duty_reg == 9'h000;
  endproperty
  a_coast: assert property (p_coast) else $error("coast not high impedance");

  property p_ramp;
    @(posedge clk_sys) disable iff (reset || !clkEn)
      entering |=> duty_reg == 9'h000 && periodCnt_reg == 9'h000;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp not from zero");

  property p_timerRestart;
    @(posedge clk_sys) disable iff (reset || !clkEn)
      !limiting_reg |=> limTimer_reg == {LT_W{1'b0}};
  endproperty
  a_timerRestart: assert property (p_timerRestart) else $error("timer not restarted");

  property p_faultKeepsDrive;
    @(posedge clk_sys) disable iff (reset || !clkEn)
      faultFlag && mode == mpvr_pkg::MPVR_FORWARD |=> drive.highA;
  endproperty
  a_faultKeepsDrive: assert property (p_faultKeepsDrive) else $error("fault stopped bridge");

  c_limiting: cover property (@(posedge clk_sys) disable iff (reset) $rose(limiting_reg));
  c_fault: cover property (@(posedge clk_sys) disable iff (reset) $rose(fault_reg));
  c_fullDuty: cover property (@(posedge clk_sys) disable iff (reset)
    duty_reg == mpvr_pkg::DUTY_FULL);
  c_reverse: cover property (@(posedge clk_sys) disable iff (reset) drive.lowA);
endmodule

// [verilog/mpvr_pkg.sv]
package mpvr_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int PWM_HZ = 44500;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
  localparam int ILIM_DEGLITCH_NS = 3000;
  localparam int ILIM_DEGLITCH_CYC = (ILIM_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ILIM_FAULT_MS = 275;
  localparam int ILIM_FAULT_CYC = ILIM_FAULT_MS * (CLK_HZ / 1000);
  localparam int RAMP_MAX_MS = 12;
  localparam int RAMP_MAX_CYC = RAMP_MAX_MS * (CLK_HZ / 1000);
  // ==========================================================
  // setpoint and feedback scaling
  localparam int SET_W = 6;
  localparam int LEVEL_W = 8;
  localparam int DUTY_W = 9;
  localparam logic [5:0] SET_RESERVED_MAX = 6'h05;
  localparam logic [5:0] SET_MIN = 6'h06;
  localparam logic [5:0] SET_MAX = 6'h3F;
  localparam int DAC_DIVISOR = 64;
  localparam int FB_DIVIDE = 4;
  localparam int VREF_MV = 1285;
  localparam logic [8:0] DUTY_FULL = 9'(PWM_PERIOD_CYC);
  localparam logic [8:0] DUTY_RESET = 9'h000;
  localparam logic [8:0] PERIOD_LAST = 9'(PWM_PERIOD_CYC - 1);
  localparam logic [6:0] DEGLITCH_LAST = 7'(ILIM_DEGLITCH_CYC);
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MPVR_COAST,
    MPVR_REVERSE,
    MPVR_FORWARD,
    MPVR_BRAKE
  } mpvr_mode_e;
  typedef struct packed {
    logic highA;
    logic lowA;
    logic highB;
    logic lowB;
  } mpvr_drive_s;
  localparam mpvr_drive_s DRIVE_OFF = 4'h0;
endpackage

// [tb/mpvr_motor_model.sv]
`timescale 1ns/1ps
module mpvr_motor_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire mpvr_pkg::mpvr_drive_s drive,
  input wire logic [7:0] supplyLevel,
  input wire logic overload,
  output logic [7:0] windingAverage,
  output logic senseResistorPin
);
  // ==========================================================
  // winding average over one pwm window, same units as supply
  logic [8:0] winCnt_reg;
  logic [8:0] onCnt_reg;
  logic driving;
  assign driving = (drive.highA & drive.lowB) | (drive.highB & drive.lowA);
  // stall current held through recirculation too: harsher than a real winding
  assign senseResistorPin = overload;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      winCnt_reg <= 9'h000;
      onCnt_reg <= 9'h000;
      windingAverage <= 8'h00;
    end else if (winCnt_reg == mpvr_pkg::PERIOD_LAST) begin
      winCnt_reg <= 9'h000;
      onCnt_reg <= 9'h000;
      windingAverage <= 8'((17'(supplyLevel) * 17'(onCnt_reg)) / 17'(mpvr_pkg::PWM_PERIOD_CYC));
    end else begin
      winCnt_reg <= winCnt_reg + 9'h001;
      onCnt_reg <= onCnt_reg + 9'(driving);
    end
  end
endmodule

// [tb/motor_pwm_voltage_regulator_tb.sv]
`timescale 1ns/1ps
module motor_pwm_voltage_regulator_tb;
  localparam int FAULT_CYC = 200;
  localparam int PER = mpvr_pkg::PWM_PERIOD_CYC;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic [1:0] bridgeCtl = 2'h0;
  logic [5:0] setpoint = 6'h00;
  logic faultResetRequest = 1'b0;
  logic overload = 1'b0;
  logic [7:0] supplyLevel = 8'hFF;
  logic [7:0] windingAverage;
  logic senseResistorPin;
  mpvr_pkg::mpvr_drive_s drive;
  logic faultOutputLow, faultFlag, currentLimitFlag, currentLimiting, regulating;
  logic [8:0] dutyLevel;
  logic [8:0] d0;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  mpvr_core #(.FAULT_CYCLES(FAULT_CYC)) u_mpvr_core (.clk_sys(clk_sys), .reset(reset),
    .clkEn(clkEn), .bridgeControlA(bridgeCtl[1]), .bridgeControlB(bridgeCtl[0]),
    .outputVoltageSetpoint(setpoint), .faultResetRequest(faultResetRequest),
    .senseResistorPin(senseResistorPin), .windingAverage(windingAverage),
    .supplyLevel(supplyLevel), .drive(drive), .faultOutputLow(faultOutputLow),
    .faultFlag(faultFlag), .currentLimitFlag(currentLimitFlag),
    .currentLimiting(currentLimiting), .regulating(regulating), .dutyLevel(dutyLevel));
  mpvr_motor_model u_mpvr_motor_model (.clk_sys(clk_sys), .reset(reset), .drive(drive),
    .supplyLevel(supplyLevel), .overload(overload), .windingAverage(windingAverage),
    .senseResistorPin(senseResistorPin));
  // ==========================================================
  // clock, timeout and helpers
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic end_of_test();
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(logic [15:0] seen, logic [15:0] expd);
    compares++;
    if (seen !== expd) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic mode(logic [1:0] m);
    @(posedge clk_sys);
    bridgeCtl <= m;
    cyc(2);
  endtask
  function automatic mpvr_pkg::mpvr_drive_s exp_drive(logic [1:0] m, logic on);
    case (m)
      2'h0: return mpvr_pkg::DRIVE_OFF;
      2'h1: return on ? 4'h6 : 4'hA;
      2'h2: return on ? 4'h9 : 4'hA;
      default: return 4'hA;
    endcase
  endfunction
  // one pwm window: every cycle must be the on or off pattern of the mode
  task automatic watch_period(logic [1:0] m);
    int onSeen;
    int bad;
    onSeen = 0;
    bad = 0;
    repeat (PER) begin
      cyc(1);
      if (drive === exp_drive(m, 1'b1)) onSeen++;
      else if (drive !== exp_drive(m, 1'b0)) bad++;
    end
    chk(16'(bad), 16'h0000);
    if (m == 2'h1 || m == 2'h2) chk(16'(onSeen > 0), 16'h0001);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [1:0] m;
    void'($urandom(32'h2D96));
    cyc(20);
    @(posedge clk_sys);
    reset <= 1'b0;
    cyc(2);
    chk(16'(faultOutputLow), 16'h0001);
    chk(16'(drive), 16'h0000);
    chk(16'(dutyLevel), 16'h0000);
    watch_period(2'h0);
    repeat (3) begin
      m = ($urandom_range(1, 0) != 0) ? 2'h2 : 2'h1;
      setpoint <= 6'($urandom_range(63, 6));
      supplyLevel <= 8'($urandom_range(255, 20));
      mode(m);
      chk(16'(dutyLevel), 16'h0000);
      cyc(4 * PER);
      watch_period(m);
      chk(16'(regulating), 16'(4 * (int'(setpoint) + 1) <= int'(supplyLevel)));
      chk(16'(dutyLevel >= 9'h003 && dutyLevel <= 9'h006), 16'h0001);
      d0 = dutyLevel;
      setpoint <= 6'($urandom_range(5, 0));
      cyc(4 * PER);
      chk(16'(dutyLevel < d0), 16'h0001);
      mode(2'h3);
      watch_period(2'h3);
      mode(m ^ 2'h3);
      chk(16'(dutyLevel), 16'h0000);
      mode(2'h0);
    end
    // full duty against a low supply, then freeze by clock enable
    setpoint <= 6'h3F;
    supplyLevel <= 8'h14;
    mode(2'h2);
    cyc(3 * PER);
    chk(16'(regulating), 16'h0000);
    d0 = dutyLevel;
    clkEn <= 1'b0;
    cyc(600);
    chk(16'(dutyLevel), 16'(d0));
    clkEn <= 1'b1;
    // short overloads restart the deglitch count
    repeat (4) begin
      overload <= 1'b1;
      cyc(40);
      chk(16'(currentLimiting), 16'h0000);
      overload <= 1'b0;
      cyc(5);
    end
    overload <= 1'b1;
    cyc(56);
    chk(16'(currentLimiting), 16'h0000);
    cyc(14);
    chk(16'(currentLimiting), 16'h0001);
    chk(16'(drive.lowB), 16'h0000);
    cyc(FAULT_CYC - 25);
    chk(16'(faultFlag), 16'h0000);
    cyc(40);
    chk(16'({faultOutputLow, faultFlag, currentLimitFlag}), 16'h0003);
    chk(16'(drive.highA), 16'h0001);
    chk(16'(currentLimiting), 16'h0001);
    overload <= 1'b0;
    cyc(10);
    chk(16'(faultFlag), 16'h0001);
    faultResetRequest <= 1'b1;
    cyc(1);
    faultResetRequest <= 1'b0;
    cyc(2);
    chk(16'({faultOutputLow, faultFlag, currentLimitFlag}), 16'h0004);
    // a limit episode shorter than the fault time must not carry over
    overload <= 1'b1;
    cyc(FAULT_CYC);
    overload <= 1'b0;
    cyc(10);
    overload <= 1'b1;
    cyc(FAULT_CYC + 50);
    chk(16'(faultFlag), 16'h0000);
    cyc(40);
    overload <= 1'b0;
    chk(16'(faultFlag), 16'h0001);
    // let limiting drop first: a set in the clearing cycle wins
    cyc(4);
    mode(2'h0);
    chk(16'({faultOutputLow, faultFlag, currentLimitFlag}), 16'h0004);
    end_of_test();
  end
endmodule
